/* shared/mcs_pkg.sv */
// Shared constants and types for the motor compensation and step mode parameter bank.
// Assumes one clock domain, sys_clk at 100 MHz, and an upstream command decoder.
// Functional notes
// - All three slopes zero means no back-EMF compensation at all.
// - Below intersect speed the start slope drives compensation.
// - Above intersect speed while accelerating, the final accel slope applies.
// - Above intersect speed while decelerating, the final decel slope applies.
// - Slope writes while running are ignored and raise command error.
// - Slope codes span zero to 0.004 s/step, 0.000015 per code.
// - Thermal code zero is factor 1, plus 0.03125 per code.
// - ADC result tracks sense input even with supply compensation off.
// - Writes to the ADC result are always dropped with command error.
// - ADC code selects supply factor, 16 is unity, saturating at 8 and below and at 24 and above.
// - Overcurrent level is (code plus one) times 31.25 mV.
// - Stall level uses the same 31.25 mV linear encoding.
// - Step mode byte: sync enable bit 7, source 6..4, resolution 2..0, bit 3 zero.
// - Resolution code 0 is full step, each code halves, 7 is 1/128.
// - A resolution change resets the electrical phase to the first microstep.
// - Step mode writes while running are ignored and raise command error.
// - Sync disabled gives low busy while executing, else a phase derived clock.
// - Sync source code n routes electrical phase bit (7 minus n).
package mcs_pkg;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [7:0] MCS_ADDR_START_SLOPE = 8'h0E;
  localparam logic [7:0] MCS_ADDR_FINAL_SLOPE_ACCEL = 8'h0F;
  localparam logic [7:0] MCS_ADDR_FINAL_SLOPE_DECEL = 8'h10;
  localparam logic [7:0] MCS_ADDR_THERMAL = 8'h11;
  localparam logic [7:0] MCS_ADDR_ADC = 8'h12;
  localparam logic [7:0] MCS_ADDR_OCD = 8'h13;
  localparam logic [7:0] MCS_ADDR_STALL = 8'h14;
  localparam logic [7:0] MCS_ADDR_STEP_MODE = 8'h16;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int MCS_SYNC_EN_BIT = 7;
  localparam int MCS_SYNC_SEL_LSB = 4;
  localparam int MCS_ZERO_BIT = 3;
  localparam int MCS_STEP_SEL_LSB = 0;
  localparam logic [7:0] MCS_SLOPE_RST = 8'h00;
  localparam logic [3:0] MCS_THERMAL_RST = 4'h0;
  localparam logic [4:0] MCS_OCD_RST = 5'h08;
  localparam logic [4:0] MCS_STALL_RST = 5'h10;
  localparam logic [7:0] MCS_STEP_MODE_RST = 8'h07;
  localparam logic [4:0] MCS_ADC_RST = 5'h10;
  // Reset views of the registered scaled outputs
  localparam logic [5:0] MCS_THERMAL_FACTOR_RST = 6'h20;
  localparam logic [11:0] MCS_OCD_MV_X4_RST = 12'h465;
  localparam logic [11:0] MCS_STALL_MV_X4_RST = 12'h84D;
  localparam logic [7:0] MCS_MICROSTEP_RST = 8'h80;
  // Threshold step in quarter millivolts per code
  localparam logic [11:0] MCS_TH_QMV_STEP = 12'h07D;

  // ****************************************
  // Scaling constants (fixed point)
  // ****************************************
  // Factors in Q1.5 (32 = 1.0)
  localparam logic [5:0] MCS_K_ONE = 6'h20;
  localparam logic [4:0] MCS_ADC_UNITY = 5'h10;
  localparam logic [4:0] MCS_ADC_HIGH_SAT = 5'h18;
  localparam logic [4:0] MCS_ADC_LOW_SAT = 5'h08;
  // Supply factors in Q1.8: 0.65625 and 1.96875 (504/256)
  localparam logic [9:0] MCS_SUPPLY_MIN = 10'h0A8;
  localparam logic [9:0] MCS_SUPPLY_MAX = 10'h1F8;
  localparam logic [9:0] MCS_SUPPLY_ONE = 10'h100;
  // Threshold step in microvolts: 31.25 mV
  localparam int MCS_TH_STEP_UV = 31250;
  // Slope step in ns/step: 0.000015 s
  localparam int MCS_SLOPE_STEP_NS = 15000;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {MCS_PHASE_HOLD, MCS_PHASE_ACCEL, MCS_PHASE_DECEL, MCS_PHASE_CONST} mcs_motion_t;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } mcs_write_t;

  typedef struct packed {
    logic sync_en;
    logic [2:0] sync_sel;
    logic [2:0] step_sel;
  } mcs_step_cfg_t;

endpackage

/* src/mcs_param_bank.sv */
// Parameter register bank: slopes, thermal factor, supply ADC, thresholds, step mode.
// Assumes a command decoder delivers one write or read per cycle, and motion engine status inputs.
`timescale 1ns/100ps
module mcs_param_bank
  import mcs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire mcs_write_t wr_cmd,
  input wire logic rd_valid,
  input wire logic [7:0] rd_addr,
  input wire logic motor_running,
  input wire logic cmd_busy,
  input wire mcs_motion_t motion,
  input wire logic [19:0] speed,
  input wire logic [19:0] intersect_speed,
  input wire logic [4:0] analog_sense_input,
  input wire logic adc_sample,
  input wire logic [7:0] electrical_phase,
  output logic [7:0] rd_data,
  output logic rd_ack,
  output logic cmd_error,
  output logic [7:0] start_slope,
  output logic [7:0] final_slope_accel,
  output logic [7:0] final_slope_decel,
  output logic [7:0] active_slope,
  output logic bemf_comp_on,
  output logic [5:0] thermal_factor,
  output logic [4:0] supply_adc_result,
  output logic [9:0] supply_factor,
  output logic [4:0] overcurrent_trip_level,
  output logic [4:0] stall_detect_level,
  output logic [11:0] overcurrent_mv_x4,
  output logic [11:0] stall_mv_x4,
  output mcs_step_cfg_t step_cfg,
  output logic [7:0] microstep_div,
  output logic phase_reset,
  output logic busy_sync
);

  // ****************************************
  // Storage
  // ****************************************
  logic [7:0] start_slope_q, start_slope_d;
  logic [7:0] final_slope_accel_q, final_slope_accel_d;
  logic [7:0] final_slope_decel_q, final_slope_decel_d;
  logic [3:0] thermal_drift_coefficient_q, thermal_drift_coefficient_d;
  logic [4:0] supply_adc_result_q, supply_adc_result_d;
  logic [4:0] overcurrent_trip_level_q, overcurrent_trip_level_d;
  logic [4:0] stall_detect_level_q, stall_detect_level_d;
  logic [7:0] resolution_and_sync_config_q, resolution_and_sync_config_d;
  logic cmd_error_q, cmd_error_d;
  logic phase_reset_q, phase_reset_d;
  logic busy_sync_q, busy_sync_d;
  logic [7:0] rd_data_q, rd_data_d;
  logic rd_ack_q, rd_ack_d;
  logic [7:0] active_slope_q;
  logic bemf_comp_on_q;
  logic [9:0] supply_factor_q;
  // Registered scaled views of the stored fields
  logic [5:0] thermal_factor_q, thermal_factor_d;
  logic [11:0] overcurrent_mv_x4_q, overcurrent_mv_x4_d;
  logic [11:0] stall_mv_x4_q, stall_mv_x4_d;
  logic [7:0] microstep_div_q, microstep_div_d;
  logic [7:0] slope_w;
  logic comp_w;
  logic [9:0] supply_w;
  logic wr_ok;

  // ****************************************
  // Helper blocks
  // ****************************************
  mcs_slope_sel u_slope_sel (
    .start_slope(start_slope_q),
    .final_slope_accel(final_slope_accel_q),
    .final_slope_decel(final_slope_decel_q),
    .speed(speed),
    .intersect_speed(intersect_speed),
    .motion(motion),
    .slope(slope_w),
    .comp_active(comp_w)
  );

  mcs_supply_map u_supply_map (
    .adc_code(supply_adc_result_q),
    .factor(supply_w)
  );

  // ****************************************
  // Write decode and protection
  // ****************************************
  // Accepted writes update, refused ones raise the error
  assign wr_ok = wr_cmd.valid && !motor_running;

  always_comb begin
    start_slope_d = start_slope_q;
    final_slope_accel_d = final_slope_accel_q;
    final_slope_decel_d = final_slope_decel_q;
    thermal_drift_coefficient_d = thermal_drift_coefficient_q;
    overcurrent_trip_level_d = overcurrent_trip_level_q;
    stall_detect_level_d = stall_detect_level_q;
    resolution_and_sync_config_d = resolution_and_sync_config_q;
    cmd_error_d = cmd_error_q;
    phase_reset_d = 1'b0;
    if (wr_cmd.valid) begin
      case (wr_cmd.addr)
        MCS_ADDR_START_SLOPE: begin
          if (wr_ok) begin
            start_slope_d = wr_cmd.data;
          end else begin
            cmd_error_d = 1'b1;
          end
        end
        MCS_ADDR_FINAL_SLOPE_ACCEL: begin
          if (wr_ok) begin
            final_slope_accel_d = wr_cmd.data;
          end else begin
            cmd_error_d = 1'b1;
          end
        end
        MCS_ADDR_FINAL_SLOPE_DECEL: begin
          if (wr_ok) begin
            final_slope_decel_d = wr_cmd.data;
          end else begin
            cmd_error_d = 1'b1;
          end
        end
        // Thermal and threshold fields are taken even while running
        MCS_ADDR_THERMAL: begin
          thermal_drift_coefficient_d = wr_cmd.data[3:0];
        end
        MCS_ADDR_ADC: begin
          cmd_error_d = 1'b1;
        end
        MCS_ADDR_OCD: begin
          overcurrent_trip_level_d = wr_cmd.data[4:0];
        end
        MCS_ADDR_STALL: begin
          stall_detect_level_d = wr_cmd.data[4:0];
        end
        MCS_ADDR_STEP_MODE: begin
          if (wr_ok) begin
            // Bit 3 is stored as zero whatever the host sends
            resolution_and_sync_config_d = wr_cmd.data & 8'hF7;
            if (wr_cmd.data[2:0] != resolution_and_sync_config_q[2:0]) begin
              phase_reset_d = 1'b1;
            end
          end else begin
            cmd_error_d = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // ADC result tracking
  // ****************************************
  // Sampled regardless of supply compensation enable
  always_comb begin
    supply_adc_result_d = supply_adc_result_q;
    if (adc_sample) begin
      supply_adc_result_d = analog_sense_input;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  // One cycle read answer, unmapped reads zero
  always_comb begin
    rd_ack_d = rd_valid;
    rd_data_d = 8'h00;
    if (rd_valid) begin
      case (rd_addr)
        MCS_ADDR_START_SLOPE: rd_data_d = start_slope_q;
        MCS_ADDR_FINAL_SLOPE_ACCEL: rd_data_d = final_slope_accel_q;
        MCS_ADDR_FINAL_SLOPE_DECEL: rd_data_d = final_slope_decel_q;
        MCS_ADDR_THERMAL: rd_data_d = {4'h0, thermal_drift_coefficient_q};
        MCS_ADDR_ADC: rd_data_d = {3'h0, supply_adc_result_q};
        MCS_ADDR_OCD: rd_data_d = {3'h0, overcurrent_trip_level_q};
        MCS_ADDR_STALL: rd_data_d = {3'h0, stall_detect_level_q};
        MCS_ADDR_STEP_MODE: rd_data_d = resolution_and_sync_config_q;
        default: rd_data_d = 8'h00;
      endcase
    end
  end

  // ****************************************
  // Busy and sync output
  // ****************************************
  // Low while busy, or phase bit (7 minus select)
  always_comb begin
    if (resolution_and_sync_config_q[MCS_SYNC_EN_BIT]) begin
      busy_sync_d = electrical_phase[3'd7 - resolution_and_sync_config_q[6:4]];
    end else begin
      busy_sync_d = !cmd_busy;
    end
  end

  // ****************************************
  // Scaled outputs
  // ****************************************
  // Worked out from the next field values, so each scaled view
  // changes in the same cycle as its field yet still leaves
  // the block from a flip-flop
  always_comb begin
    // Thermal factor in Q1.5: one plus code over 32
    thermal_factor_d = MCS_K_ONE + {2'b00, thermal_drift_coefficient_d};

    // Thresholds in quarter millivolts: (code plus one) times 125
    // Code 31 gives 4000, so the sum and product are kept at twelve bits
    overcurrent_mv_x4_d = ({7'h00, overcurrent_trip_level_d} + 12'h001) * MCS_TH_QMV_STEP;
    stall_mv_x4_d = ({7'h00, stall_detect_level_d} + 12'h001) * MCS_TH_QMV_STEP;

    // Microsteps per full step: 1 at full step up to 128
    // Follows the stored select, so a refused write leaves it alone
    microstep_div_d = 8'h01 << resolution_and_sync_config_d[2:0];
  end

  // ****************************************
  // Registers
  // ****************************************
  // Register all state, error flag sticky until reset
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      start_slope_q <= MCS_SLOPE_RST;
      final_slope_accel_q <= MCS_SLOPE_RST;
      final_slope_decel_q <= MCS_SLOPE_RST;
      thermal_drift_coefficient_q <= MCS_THERMAL_RST;
      supply_adc_result_q <= MCS_ADC_RST;
      overcurrent_trip_level_q <= MCS_OCD_RST;
      stall_detect_level_q <= MCS_STALL_RST;
      resolution_and_sync_config_q <= MCS_STEP_MODE_RST;
      cmd_error_q <= 1'b0;
      phase_reset_q <= 1'b0;
      busy_sync_q <= 1'b1;
      rd_data_q <= 8'h00;
      rd_ack_q <= 1'b0;
      active_slope_q <= 8'h00;
      bemf_comp_on_q <= 1'b0;
      supply_factor_q <= MCS_SUPPLY_ONE;
      thermal_factor_q <= MCS_THERMAL_FACTOR_RST;
      overcurrent_mv_x4_q <= MCS_OCD_MV_X4_RST;
      stall_mv_x4_q <= MCS_STALL_MV_X4_RST;
      microstep_div_q <= MCS_MICROSTEP_RST;
    end else begin
      start_slope_q <= start_slope_d;
      final_slope_accel_q <= final_slope_accel_d;
      final_slope_decel_q <= final_slope_decel_d;
      thermal_drift_coefficient_q <= thermal_drift_coefficient_d;
      supply_adc_result_q <= supply_adc_result_d;
      overcurrent_trip_level_q <= overcurrent_trip_level_d;
      stall_detect_level_q <= stall_detect_level_d;
      resolution_and_sync_config_q <= resolution_and_sync_config_d;
      cmd_error_q <= cmd_error_d;
      phase_reset_q <= phase_reset_d;
      busy_sync_q <= busy_sync_d;
      rd_data_q <= rd_data_d;
      rd_ack_q <= rd_ack_d;
      active_slope_q <= slope_w;
      bemf_comp_on_q <= comp_w;
      supply_factor_q <= supply_w;
      thermal_factor_q <= thermal_factor_d;
      overcurrent_mv_x4_q <= overcurrent_mv_x4_d;
      stall_mv_x4_q <= stall_mv_x4_d;
      microstep_div_q <= microstep_div_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Straight register outputs and fixed scalings
  assign start_slope = start_slope_q;
  assign final_slope_accel = final_slope_accel_q;
  assign final_slope_decel = final_slope_decel_q;
  assign active_slope = active_slope_q;
  assign bemf_comp_on = bemf_comp_on_q;
  assign thermal_factor = thermal_factor_q;
  assign supply_adc_result = supply_adc_result_q;
  assign supply_factor = supply_factor_q;
  assign overcurrent_trip_level = overcurrent_trip_level_q;
  assign stall_detect_level = stall_detect_level_q;
  // Scaled views, registered above
  assign overcurrent_mv_x4 = overcurrent_mv_x4_q;
  assign stall_mv_x4 = stall_mv_x4_q;
  assign step_cfg.sync_en = resolution_and_sync_config_q[MCS_SYNC_EN_BIT];
  assign step_cfg.sync_sel = resolution_and_sync_config_q[6:4];
  assign step_cfg.step_sel = resolution_and_sync_config_q[2:0];
  assign microstep_div = microstep_div_q;
  assign phase_reset = phase_reset_q;
  assign busy_sync = busy_sync_q;
  assign cmd_error = cmd_error_q;
  assign rd_data = rd_data_q;
  assign rd_ack = rd_ack_q;

endmodule

/* src/mcs_slope_sel.sv */
// Picks the back-EMF slope from speed region and motion direction.
// Assumes speed and intersect speed share one unit.
`timescale 1ns/100ps
module mcs_slope_sel
  import mcs_pkg::*;
(
  input wire logic [7:0] start_slope,
  input wire logic [7:0] final_slope_accel,
  input wire logic [7:0] final_slope_decel,
  input wire logic [19:0] speed,
  input wire logic [19:0] intersect_speed,
  input wire mcs_motion_t motion,
  output logic [7:0] slope,
  output logic comp_active
);

  // ****************************************
  // Slope choice
  // ****************************************
  // Region and direction pick one slope
  always_comb begin
    comp_active = (start_slope | final_slope_accel | final_slope_decel) != 8'h00;
    if (speed < intersect_speed) begin
      slope = start_slope;
    end else if (motion == MCS_PHASE_DECEL) begin
      slope = final_slope_decel;
    end else if (motion == MCS_PHASE_ACCEL) begin
      slope = final_slope_accel;
    end else begin
      slope = final_slope_accel;
    end
    if (!comp_active) begin
      slope = 8'h00;
    end
  end

endmodule

/* src/mcs_supply_map.sv */
// Maps the supply ADC code to a compensation factor in Q1.8.
// Assumes factor is 16/code, saturated at codes 8 and below and 24 and above.
`timescale 1ns/100ps
module mcs_supply_map
  import mcs_pkg::*;
(
  input wire logic [4:0] adc_code,
  output logic [9:0] factor
);

  // ****************************************
  // Reciprocal map
  // ****************************************
  // Saturating 4096/code table
  always_comb begin
    if (adc_code >= MCS_ADC_HIGH_SAT) begin
      factor = MCS_SUPPLY_MIN;
    end else if (adc_code <= MCS_ADC_LOW_SAT) begin
      factor = MCS_SUPPLY_MAX;
    end else if (adc_code == MCS_ADC_UNITY) begin
      factor = MCS_SUPPLY_ONE;
    end else begin
      factor = 10'(16'h1000 / {11'h000, adc_code});
    end
  end

endmodule

/* testbench/mcs_host_model.sv */
// Host model: issues parameter writes and reads at the falling edge.
// Assumes the bank samples requests on the rising edge of sys_clk.
`timescale 1ns/100ps
module mcs_host_model
  import mcs_pkg::*;
(
  input wire logic sys_clk,
  output mcs_write_t wr_cmd,
  output logic rd_valid,
  output logic [7:0] rd_addr
);
  initial begin
    wr_cmd = '0;
    rd_valid = 1'b0;
    rd_addr = 8'h00;
  end
  // One write pulse; released lines show the inverse
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    wr_cmd.valid = 1'b1;
    wr_cmd.addr = a;
    // Bit 3 sent as zero on step mode writes
    wr_cmd.data = (a == MCS_ADDR_STEP_MODE) ? (d & 8'hF7) : d;
    @(negedge sys_clk);
    wr_cmd = {1'b0, ~wr_cmd.addr, ~wr_cmd.data};
  endtask
  // One read pulse
  task automatic rd(input logic [7:0] a);
    @(negedge sys_clk);
    rd_valid = 1'b1;
    rd_addr = a;
    @(negedge sys_clk);
    rd_valid = 1'b0;
    rd_addr = ~a;
  endtask
endmodule

/* testbench/mcs_param_bank_props.sv */
// Concurrent checks on the parameter bank ports.
// Assumes one rising-edge clock sys_clk and async active-low reset_n.
`timescale 1ns/100ps
module mcs_param_bank_props
  import mcs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire mcs_write_t wr_cmd,
  input wire logic motor_running,
  input wire logic cmd_busy,
  input wire logic [4:0] analog_sense_input,
  input wire logic adc_sample,
  input wire logic [7:0] electrical_phase,
  input wire logic cmd_error,
  input wire logic [7:0] start_slope,
  input wire logic [7:0] final_slope_accel,
  input wire logic [7:0] final_slope_decel,
  input wire logic bemf_comp_on,
  input wire logic [4:0] supply_adc_result,
  input wire logic [9:0] supply_factor,
  input wire mcs_step_cfg_t step_cfg,
  input wire logic phase_reset,
  input wire logic busy_sync
);
  logic sync_src_d;
  logic sync_src_q;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  // ****
  // Helper: selected phase bit one cycle back
  // ****
  always_comb sync_src_d = electrical_phase[3'd7 - step_cfg.sync_sel];
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) sync_src_q <= 1'b0;
    else sync_src_q <= sync_src_d;
  end
  // ****
  // Properties
  // ****
  property p_slope_ro;
    wr_cmd.valid && motor_running && wr_cmd.addr inside {8'h0E, 8'h0F, 8'h10}
      |=> $stable({start_slope, final_slope_accel, final_slope_decel}) && cmd_error;
  endproperty
  a_slope_ro: assert property (p_slope_ro) else $error("slope write taken while running");
  property p_adc_wr;
    wr_cmd.valid && wr_cmd.addr == MCS_ADDR_ADC && !adc_sample |=> cmd_error && $stable(supply_adc_result);
  endproperty
  a_adc_wr: assert property (p_adc_wr) else $error("adc result write not refused");
  property p_step_ro;
    wr_cmd.valid && motor_running && wr_cmd.addr == MCS_ADDR_STEP_MODE |=> $stable(step_cfg) && !phase_reset && cmd_error;
  endproperty
  a_step_ro: assert property (p_step_ro) else $error("step mode write taken while running");
  property p_comp_off;
    start_slope == 8'h00 && final_slope_accel == 8'h00 && final_slope_decel == 8'h00 |=> !bemf_comp_on;
  endproperty
  a_comp_off: assert property (p_comp_off) else $error("compensation on with zero slopes");
  property p_adc_track;
    adc_sample |=> supply_adc_result == $past(analog_sense_input);
  endproperty
  a_adc_track: assert property (p_adc_track) else $error("adc result not loaded");
  property p_sat_hi;
    supply_adc_result >= MCS_ADC_HIGH_SAT |=> supply_factor == MCS_SUPPLY_MIN;
  endproperty
  a_sat_hi: assert property (p_sat_hi) else $error("high supply factor not saturated");
  property p_sat_lo;
    supply_adc_result <= MCS_ADC_LOW_SAT |=> supply_factor == MCS_SUPPLY_MAX;
  endproperty
  a_sat_lo: assert property (p_sat_lo) else $error("low supply factor not saturated");
  property p_phase_rst;
    wr_cmd.valid && !motor_running && wr_cmd.addr == MCS_ADDR_STEP_MODE && wr_cmd.data[2:0] != step_cfg.step_sel
      |=> phase_reset ##1 !phase_reset;
  endproperty
  a_phase_rst: assert property (p_phase_rst) else $error("no phase reset pulse");
  property p_sync;
    step_cfg.sync_en |=> busy_sync == sync_src_q;
  endproperty
  a_sync: assert property (p_sync) else $error("sync output wrong phase bit");
  property p_busy;
    !step_cfg.sync_en && cmd_busy |=> !busy_sync ##1 (busy_sync == !$past(cmd_busy) || step_cfg.sync_en);
  endproperty
  a_busy: assert property (p_busy) else $error("busy output not low");
endmodule

bind mcs_param_bank mcs_param_bank_props u_props (.*);

/* testbench/mcs_param_bank_tb.sv */
// Self-checking bench for the parameter bank.
// Assumes the host model drives requests; read results are checked from a queue.
`timescale 1ns/100ps
module mcs_param_bank_tb;
  import mcs_pkg::*;
  logic sys_clk, reset_n, motor_running, cmd_busy, adc_sample, rd_valid, rd_ack, cmd_error, bemf_comp_on;
  logic phase_reset, busy_sync;
  logic [7:0] rd_addr, rd_data, electrical_phase, start_slope, final_slope_accel, final_slope_decel;
  logic [7:0] active_slope, microstep_div, v;
  logic [19:0] speed, intersect_speed;
  logic [4:0] analog_sense_input, supply_adc_result, overcurrent_trip_level, stall_detect_level;
  logic [5:0] thermal_factor;
  logic [9:0] supply_factor;
  logic [11:0] overcurrent_mv_x4, stall_mv_x4;
  mcs_write_t wr_cmd;
  mcs_motion_t motion;
  mcs_step_cfg_t step_cfg;
  int bad_count, compares, i;
  logic [7:0] exp_q[$];
  logic [7:0] addrs[9] = '{8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h16, 8'h15};
  logic [7:0] rstv[9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h08, 8'h10, 8'h07, 8'h00};
  logic [7:0] msk[8] = '{8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h00, 8'h1F, 8'h1F, 8'hF7};
  logic [4:0] adc_codes[7] = '{5'h00, 5'h08, 5'h09, 5'h10, 5'h17, 5'h18, 5'h1F};
  mcs_param_bank u_dut (.*);
  mcs_host_model u_host (.*);
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ****
  // Shared tasks
  // ****
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic do_reset();
    reset_n = 1'b0;
    tick(10);
    reset_n = 1'b1;
  endtask
  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.rd(a);
  endtask
  task automatic comp(input mcs_motion_t m, input logic [19:0] s, input logic [7:0] e);
    motion = m;
    speed = s;
    tick(3);
    chk(active_slope, e);
    chk(bemf_comp_on, 1);
  endtask
  task automatic test_done();
    $display("Compares %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Read monitor: oldest expected value against each answer
  always @(negedge sys_clk) if (rd_ack === 1'b1) chk(rd_data, exp_q.pop_front());
  // Watchdog
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    test_done();
  end
  // ****
  // Main sequence
  // ****
  initial begin
    reset_n = 1'b0;
    motor_running = 1'b0;
    cmd_busy = 1'b0;
    adc_sample = 1'b0;
    electrical_phase = 8'h00;
    speed = 20'h0_0000;
    intersect_speed = 20'h0_8000;
    motion = MCS_PHASE_HOLD;
    analog_sense_input = 5'h10;
    void'($urandom(32'h8f84ccd8));
    do_reset();
    foreach (addrs[k]) rdx(addrs[k], rstv[k]);
    tick(2);
    chk(cmd_error, 0);
    chk(bemf_comp_on, 0);
    u_host.wr(8'h12, 8'h05);
    rdx(8'h12, 8'h10);
    chk(cmd_error, 1);
    $display("Reset values and read-only test done");
    do_reset();
    for (i = 0; i < 8; i++) begin
      v = 8'($urandom);
      if (i != 4) u_host.wr(addrs[i], v);
      if (i != 4) rdx(addrs[i], v & msk[i]);
    end
    for (i = 0; i < 16; i++) begin
      u_host.wr(8'h11, i[7:0]);
      chk(thermal_factor, 16'd32 + i[15:0]);
    end
    chk(cmd_error, 0);
    $display("Write and read back test done");
    u_host.wr(8'h0E, 8'h11);
    u_host.wr(8'h0F, 8'h22);
    u_host.wr(8'h10, 8'h33);
    u_host.wr(8'h16, 8'h05);
    motor_running = 1'b1;
    for (i = 0; i < 4; i++) u_host.wr(i == 3 ? 8'h16 : addrs[i], 8'hAA);
    rdx(8'h0E, 8'h11);
    rdx(8'h0F, 8'h22);
    rdx(8'h10, 8'h33);
    rdx(8'h16, 8'h05);
    chk(cmd_error, 1);
    u_host.wr(8'h13, 8'h1F);
    rdx(8'h13, 8'h1F);
    chk(overcurrent_trip_level, 16'h001F);
    chk(overcurrent_mv_x4, 32 * MCS_TH_STEP_UV / 250);
    u_host.wr(8'h14, 8'h00);
    chk(stall_detect_level, 16'h0000);
    chk(stall_mv_x4, MCS_TH_STEP_UV / 250);
    comp(MCS_PHASE_ACCEL, $urandom_range(20'h0_7FFF), 8'h11);
    comp(MCS_PHASE_ACCEL, $urandom_range(20'hF_FFFF, 20'h0_8001), 8'h22);
    comp(MCS_PHASE_DECEL, $urandom_range(20'hF_FFFF, 20'h0_8001), 8'h33);
    comp(MCS_PHASE_CONST, $urandom_range(20'hF_FFFF, 20'h0_8001), 8'h22);
    motor_running = 1'b0;
    $display("Running protection and slope test done");
    foreach (adc_codes[k]) begin
      analog_sense_input = adc_codes[k];
      adc_sample = 1'b1;
      tick(1);
      adc_sample = 1'b0;
      analog_sense_input = ~adc_codes[k];
      tick(2);
      chk(supply_adc_result, adc_codes[k]);
      chk(supply_factor, adc_codes[k] >= MCS_ADC_HIGH_SAT ? MCS_SUPPLY_MIN
        : adc_codes[k] <= MCS_ADC_LOW_SAT ? MCS_SUPPLY_MAX : 16'h1000 / adc_codes[k]);
      rdx(8'h12, adc_codes[k]);
    end
    $display("Supply compensation test done");
    for (i = 0; i < 8; i++) begin
      u_host.wr(8'h16, {1'b1, i[2:0], 1'b0, i[2:0]});
      electrical_phase = 8'($urandom);
      tick(2);
      chk(busy_sync, electrical_phase[7 - i]);
      chk(microstep_div, 8'h01 << i);
    end
    u_host.wr(8'h16, 8'h00);
    cmd_busy = 1'b1;
    tick(2);
    chk(busy_sync, 0);
    cmd_busy = 1'b0;
    tick(2);
    chk(busy_sync, 1);
    $display("Sync output test done");
    tick(4);
    test_done();
  end
endmodule
